// *** ncm_pkg.sv ***
package ncm_pkg;
  // Command codes
  localparam logic [7:0] CMD_READ1 = 8'h00;
  localparam logic [7:0] CMD_READ2 = 8'h30;
  localparam logic [7:0] CMD_CACHE_RD = 8'h31;
  localparam logic [7:0] CMD_CACHE_LAST = 8'h3f;
  localparam logic [7:0] CMD_MP_RD = 8'h60;
  localparam logic [7:0] CMD_PROG1 = 8'h80;
  localparam logic [7:0] CMD_PROG_MP2 = 8'h81;
  localparam logic [7:0] CMD_COL_CHG = 8'h85;
  localparam logic [7:0] CMD_PROG_GO = 8'h10;
  localparam logic [7:0] CMD_PROG_MP = 8'h11;
  localparam logic [7:0] CMD_PROG_CACHE = 8'h15;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_RESET = 8'hff;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_COL = 8'h04;
  localparam logic [7:0] OFS_ROW = 8'h08;
  localparam logic [7:0] OFS_ROW2 = 8'h0c;
  localparam logic [7:0] OFS_WDATA = 8'h10;
  localparam logic [7:0] OFS_RDATA = 8'h14;
  localparam logic [7:0] OFS_STAT = 8'h18;
  // Status byte bit positions
  localparam int ST_FAIL_CUR = 0;
  localparam int ST_FAIL_PREV = 1;
  localparam int ST_PB_RDY = 5;
  localparam int ST_DC_RDY = 6;
  // Pin timing: strobe low / high phase in clk cycles
  localparam int STROBE_NS = 100;
  localparam int CLK_NS = 100;
  localparam int STROBE_CYC = (STROBE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [2:0] ADDR_CYCLES = 3'h5;
  localparam logic [2:0] COL_CYCLES = 3'h2;
  // Operations ordered by software
  typedef enum logic [3:0] {
    OP_READ, OP_CACHE_RD, OP_CACHE_LAST, OP_MP_READ, OP_PROG,
    OP_MP_PROG, OP_CACHE_PROG, OP_CACHE_END, OP_COL_CHG, OP_STATUS,
    OP_RESET, OP_DATA_WR, OP_DATA_RD
  } ncm_op_e;
  typedef struct packed {
    logic cle;
    logic ale;
    logic ce_n;
    logic we_n;
    logic re_n;
    logic wp_n;
  } ncm_ctl_s;
endpackage

// *** ncm_sync.sv ***
`timescale 1ns/1ps
module ncm_sync #(
  parameter int W = 1
) (
  // Clock, reset
  input wire logic clk,
  input wire logic nrst,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_r;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s1_r <= '0;
      q <= '0;
    end
    else
    begin
      s1_r <= d;
      q <= s1_r;
    end
  end
endmodule

// *** ncm_strobe.sv ***
`timescale 1ns/1ps
module ncm_strobe (
  // Clock, reset
  input wire logic clk,
  input wire logic nrst,
  // Pulse request and state
  input wire logic start,
  output logic low,
  output logic done
);
  // Low phase then high phase, each STROBE_CYC long
  logic [3:0] cnt_r;
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_r <= 4'h0;
      low <= 1'b0;
      done <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (start && cnt_r == 4'h0)
      begin
        cnt_r <= 4'(2 * ncm_pkg::STROBE_CYC);
        low <= 1'b1;
      end
      else if (cnt_r != 4'h0)
      begin
        cnt_r <= cnt_r - 4'h1;
        if (cnt_r == 4'(ncm_pkg::STROBE_CYC + 1))
          low <= 1'b0;
        if (cnt_r == 4'h1)
          done <= 1'b1;
      end
    end
  end
endmodule

// *** ncm_host.sv ***
// The implementer's own choices: the address map and the APB interface to the registers.
`timescale 1ns/1ps
// Contract
// R1: Command with cle, address with ale
// R2: Address is five byte cycles, zeros above
// R3: While busy only status/reset, strobes high
// R4: 31h copies buffer to cache, loads next
// R5: First read busy at most array load
// R6: 31h busy period shown on busy line
// R7: Next page load overlaps serial output
// R8: Later 31h waits for pending load
// R9: 3Fh moves last page, no new read
// R10: Multi read: 60h, 60h, 30h, same page
// R11: 30h starts two-district transfer, busy
// R12: After ready, data from given column
// R13: Two districts, even/odd, same half pair
// R14: At most one block per district
// R15: District addresses in any order
// R16: Guard pin high during multi read
// R17: 10h starts programming after data
// R18: 85h plus two cycles sets column
// R19: Multi program: bit one any fail
// R20: Between 11h and 81h only 70h/FFh; host refuses none, and any later go that is not refused and is not 11h (70h too) clears pend_r
// R21: 15h moves cache, busy cache load time
// R22: Program N while loading N+1
// R23: Later 15h waits previous program
// R24: Cache program ends with 10h
// R25: Bit one current, bit two previous page
// R26: Bit one valid at bit six, two at seven
module ncm_host (
  // Clock, reset
  input wire logic clk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Flash pins
  output ncm_pkg::ncm_ctl_s pin_ctl,
  output logic [7:0] io_out,
  output logic io_oe,
  input wire logic [7:0] io_in,
  input wire logic busy_indicator_n
);
  typedef enum logic [2:0] {
    S_IDLE, S_CMD1, S_ADDR, S_ADDR2, S_CMD2, S_DATA, S_WAIT, S_DONE
  } ncm_state_e;

  ncm_state_e st_r;
  ncm_pkg::ncm_op_e op_r;
  logic [15:0] col_r;
  logic [17:0] row_r;
  logic [17:0] row2_r;
  logic [7:0] wdata_r;
  logic [7:0] rdata_r;
  logic [7:0] stat_r;
  logic [2:0] acnt_r;
  logic go_r;
  logic err_r;
  logic pend_r;
  logic rb_s;
  logic [7:0] io_s;
  logic stb_start;
  logic stb_low;
  logic stb_done;
  logic is_cmd_phase;
  logic is_addr_phase;
  logic is_rd;
  logic [7:0] addr_byte;
  logic [7:0] cmd1;
  logic [7:0] cmd2;
  logic [17:0] cur_row;
  logic ab_write;
  logic bad_pair;
  logic is_prog;
  logic second_r;

  ncm_sync #(.W(1)) u_rb (
    .clk(clk), .nrst(nrst), .d(busy_indicator_n), .q(rb_s)
  );
  ncm_sync #(.W(8)) u_io (
    .clk(clk), .nrst(nrst), .d(io_in), .q(io_s)
  );
  ncm_strobe u_stb (
    .clk(clk), .nrst(nrst), .start(stb_start), .low(stb_low),
    .done(stb_done)
  );

  // Same half, opposite parity and same page, or the device rejects the pair
  assign bad_pair = (row_r[17] != row2_r[17])
    || (row_r[6] == row2_r[6])
    || (row_r[5:0] != row2_r[5:0]); // [R10] [R13] [R14]

  assign ab_write = psel && penable && pwrite && pready;
  assign cur_row = (st_r == S_ADDR2) ? row2_r : row_r; // [R15]

  always_comb
  begin
    cmd1 = ncm_pkg::CMD_READ1;
    cmd2 = 8'h00;
    case (op_r)
      ncm_pkg::OP_READ: cmd2 = ncm_pkg::CMD_READ2;
      ncm_pkg::OP_CACHE_RD: cmd1 = ncm_pkg::CMD_CACHE_RD; // [R4] [R8]
      ncm_pkg::OP_CACHE_LAST: cmd1 = ncm_pkg::CMD_CACHE_LAST; // [R9]
      ncm_pkg::OP_MP_READ:
      begin
        cmd1 = ncm_pkg::CMD_MP_RD;
        cmd2 = ncm_pkg::CMD_READ2; // [R11]
      end
      ncm_pkg::OP_PROG:
      begin
        cmd1 = pend_r ? ncm_pkg::CMD_PROG_MP2 : ncm_pkg::CMD_PROG1;
        cmd2 = ncm_pkg::CMD_PROG_GO; // [R17] [R24]
      end
      ncm_pkg::OP_MP_PROG:
      begin
        cmd1 = ncm_pkg::CMD_PROG1;
        cmd2 = ncm_pkg::CMD_PROG_MP; // [R20]
      end
      ncm_pkg::OP_CACHE_PROG:
      begin
        cmd1 = pend_r ? ncm_pkg::CMD_PROG_MP2 : ncm_pkg::CMD_PROG1;
        cmd2 = ncm_pkg::CMD_PROG_CACHE; // [R21] [R23]
      end
      ncm_pkg::OP_CACHE_END:
      begin
        cmd1 = pend_r ? ncm_pkg::CMD_PROG_MP2 : ncm_pkg::CMD_PROG1;
        cmd2 = ncm_pkg::CMD_PROG_GO; // [R24]
      end
      ncm_pkg::OP_COL_CHG: cmd1 = ncm_pkg::CMD_COL_CHG; // [R18]
      ncm_pkg::OP_STATUS: cmd1 = ncm_pkg::CMD_STATUS;
      ncm_pkg::OP_RESET: cmd1 = ncm_pkg::CMD_RESET;
      default: cmd1 = 8'h00;
    endcase
  end

  // Five cycles: two column, three row, upper bits zero
  always_comb
  begin
    case (acnt_r)
      3'h0: addr_byte = col_r[7:0];
      3'h1: addr_byte = {3'h0, col_r[12:8]};
      3'h2: addr_byte = cur_row[7:0];
      3'h3: addr_byte = cur_row[15:8];
      3'h4: addr_byte = {6'h00, cur_row[17:16]};
      default: addr_byte = 8'h00;
    endcase
  end // [R2]

  assign is_cmd_phase = (st_r == S_CMD1) || (st_r == S_CMD2);
  assign is_addr_phase = (st_r == S_ADDR) || (st_r == S_ADDR2);
  assign is_rd = (st_r == S_DATA) && (op_r == ncm_pkg::OP_DATA_RD
    || op_r == ncm_pkg::OP_STATUS);
  assign is_prog = (op_r == ncm_pkg::OP_PROG)
    || (op_r == ncm_pkg::OP_MP_PROG) || (op_r == ncm_pkg::OP_CACHE_PROG)
    || (op_r == ncm_pkg::OP_CACHE_END);
  // No restart on the done edge: a stray strobe would land while busy
  assign stb_start = ((st_r == S_CMD1) || (st_r == S_CMD2)
    || is_addr_phase || (st_r == S_DATA && acnt_r == 3'h0))
    && !stb_done; // [R3]

  // APB slave, zero wait states
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      pready <= 1'b0;
    else
      pready <= psel && !penable;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pslverr <= 1'b0;
      if (psel && !penable)
      begin
        case (paddr)
          ncm_pkg::OFS_CTRL: prdata <= {26'h0, err_r, go_r, op_r};
          ncm_pkg::OFS_COL: prdata <= {16'h0, col_r};
          ncm_pkg::OFS_ROW: prdata <= {14'h0, row_r};
          ncm_pkg::OFS_ROW2: prdata <= {14'h0, row2_r};
          ncm_pkg::OFS_WDATA: prdata <= {24'h0, wdata_r};
          ncm_pkg::OFS_RDATA: prdata <= {24'h0, rdata_r};
          ncm_pkg::OFS_STAT: prdata <= {23'h0, rb_s, stat_r};
          default:
          begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      col_r <= 16'h0000;
      row_r <= 18'h00000;
      row2_r <= 18'h00000;
      wdata_r <= 8'h00;
      op_r <= ncm_pkg::OP_READ;
    end
    else if (ab_write && st_r == S_IDLE)
    begin
      case (paddr)
        ncm_pkg::OFS_CTRL: op_r <= ncm_pkg::ncm_op_e'(pwdata[3:0]);
        ncm_pkg::OFS_COL: col_r <= pwdata[15:0];
        ncm_pkg::OFS_ROW: row_r <= pwdata[17:0];
        ncm_pkg::OFS_ROW2: row2_r <= pwdata[17:0];
        ncm_pkg::OFS_WDATA: wdata_r <= pwdata[7:0];
        default: ;
      endcase
    end
  end

  // Sequencer
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      st_r <= S_IDLE;
      acnt_r <= 3'h0;
      go_r <= 1'b0;
      err_r <= 1'b0;
      pend_r <= 1'b0;
      second_r <= 1'b0;
      rdata_r <= 8'h00;
      stat_r <= 8'h00;
    end
    else
    begin
      case (st_r)
        S_IDLE:
        begin
          acnt_r <= 3'h0;
          second_r <= 1'b0;
          if (ab_write && paddr == ncm_pkg::OFS_CTRL && pwdata[4])
          begin
            go_r <= 1'b1;
            err_r <= 1'b0;
            st_r <= S_CMD1;
            // Data bytes carry no command byte of their own
            if (pwdata[3:0] == 4'(ncm_pkg::OP_DATA_RD)
              || pwdata[3:0] == 4'(ncm_pkg::OP_DATA_WR))
              st_r <= S_DATA;
            // Only status or reset may go while device busy
            if ((!rb_s && pwdata[3:0] != 4'(ncm_pkg::OP_STATUS)
              && pwdata[3:0] != 4'(ncm_pkg::OP_RESET))
              || (pwdata[3:0] == 4'(ncm_pkg::OP_MP_READ) && bad_pair))
            begin
              err_r <= 1'b1; // [R3]
              go_r <= 1'b0;
              st_r <= S_IDLE;
            end
          end
        end
        S_CMD1:
          if (stb_done)
          begin
            case (op_r)
              ncm_pkg::OP_READ, ncm_pkg::OP_MP_READ, ncm_pkg::OP_PROG,
              ncm_pkg::OP_MP_PROG, ncm_pkg::OP_CACHE_PROG,
              ncm_pkg::OP_CACHE_END:
                st_r <= S_ADDR;
              ncm_pkg::OP_COL_CHG:
                st_r <= S_ADDR;
              ncm_pkg::OP_STATUS, ncm_pkg::OP_DATA_RD,
              ncm_pkg::OP_DATA_WR:
                st_r <= S_DATA;
              default:
                st_r <= S_WAIT; // [R6] [R9]
            endcase
            if (op_r == ncm_pkg::OP_MP_READ && second_r)
              st_r <= S_ADDR2; // [R10]
          end
        S_ADDR, S_ADDR2:
          if (stb_done)
          begin
            acnt_r <= acnt_r + 3'h1;
            if ((op_r == ncm_pkg::OP_COL_CHG
              && acnt_r == ncm_pkg::COL_CYCLES - 3'h1)) // [R18]
              st_r <= S_DONE;
            else if (acnt_r == ncm_pkg::ADDR_CYCLES - 3'h1)
            begin
              acnt_r <= 3'h0;
              // Second district address follows another 60h
              if (op_r == ncm_pkg::OP_MP_READ && st_r == S_ADDR)
              begin
                st_r <= S_CMD1; // [R10]
                second_r <= 1'b1;
              end
              else if (op_r == ncm_pkg::OP_READ
                || op_r == ncm_pkg::OP_MP_READ)
                st_r <= S_CMD2;
              else if (is_prog)
                st_r <= S_DATA; // [R17]
              else
                st_r <= S_DONE;
            end
          end
        S_DATA:
          if (acnt_r != 3'h0)
          begin
            acnt_r <= acnt_r + 3'h1;
            // Byte needs two sync flops after the strobe rises
            if (acnt_r == 3'h2)
            begin
              if (op_r == ncm_pkg::OP_STATUS)
                stat_r <= io_s; // [R19] [R25] [R26]
              else
                rdata_r <= io_s; // [R7] [R12]
              acnt_r <= 3'h0;
              st_r <= S_DONE;
            end
          end
          else if (stb_done)
          begin
            if (is_rd)
              acnt_r <= 3'h1;
            else if (is_prog)
              st_r <= S_CMD2; // [R17] [R21]
            else
              st_r <= S_DONE;
          end
        S_CMD2:
          if (stb_done)
            st_r <= S_WAIT; // [R5] [R11]
        S_WAIT:
          // Sync delay lets busy fall before ready is trusted
          if (rb_s && !stb_low && acnt_r == 3'h3)
            st_r <= S_DONE;
          else if (acnt_r != 3'h3)
            acnt_r <= acnt_r + 3'h1;
        S_DONE:
        begin
          go_r <= 1'b0;
          pend_r <= (op_r == ncm_pkg::OP_MP_PROG); // [R20]
          st_r <= S_IDLE;
        end
        default: st_r <= S_IDLE;
      endcase
    end
  end

  // Program commands issue their second byte in the same go, right after one data byte
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pin_ctl <= '{cle: 1'b0, ale: 1'b0, ce_n: 1'b1, we_n: 1'b1,
        re_n: 1'b1, wp_n: 1'b1};
      io_out <= 8'h00;
      io_oe <= 1'b0;
    end
    else
    begin
      pin_ctl.cle <= is_cmd_phase; // [R1]
      pin_ctl.ale <= is_addr_phase; // [R1]
      pin_ctl.ce_n <= (st_r == S_IDLE) && !go_r;
      pin_ctl.we_n <= !(stb_low && !is_rd); // [R3]
      pin_ctl.re_n <= !(stb_low && is_rd); // [R3]
      pin_ctl.wp_n <= 1'b1; // [R16]
      io_oe <= (is_cmd_phase || is_addr_phase || st_r == S_DATA)
        && !is_rd;
      if (st_r == S_CMD1)
        io_out <= cmd1;
      else if (st_r == S_CMD2)
        io_out <= cmd2; // [R22]
      else if (is_addr_phase)
        io_out <= addr_byte;
      else
        io_out <= wdata_r;
    end
  end

  a_no_both_strobes: assert property (@(posedge clk) disable iff (!nrst)
    !(!pin_ctl.we_n && !pin_ctl.re_n))
    else $error("both strobes low"); // [R3]
  a_cmd_latch_sel: assert property (@(posedge clk) disable iff (!nrst)
    !(pin_ctl.cle && pin_ctl.ale))
    else $error("cle and ale both high"); // [R1]
  a_addr_upper_low: assert property (@(posedge clk) disable iff (!nrst)
    (is_addr_phase && acnt_r == 3'h4) |=> io_out[7:2] == 6'h00)
    else $error("fifth address byte upper bits set"); // [R2]
  a_guard_high: assert property (@(posedge clk) disable iff (!nrst)
    pin_ctl.wp_n)
    else $error("guard pin dropped"); // [R16]
  a_wait_ready: assert property (@(posedge clk) disable iff (!nrst)
    (st_r == S_DONE && $past(st_r) == S_WAIT) |-> $past(rb_s))
    else $error("left wait while busy"); // [R5]
  a_busy_refuse: assert property (@(posedge clk) disable iff (!nrst)
    (st_r == S_IDLE && ab_write && paddr == ncm_pkg::OFS_CTRL
    && pwdata[4] && !rb_s && pwdata[3:0] == 4'(ncm_pkg::OP_READ))
    |=> err_r && st_r == S_IDLE)
    else $error("command issued while busy"); // [R3]
  a_cmd2_follows: assert property (@(posedge clk) disable iff (!nrst)
    (st_r == S_CMD2 && stb_done) |=> st_r == S_WAIT)
    else $error("no wait after second command"); // [R11]
  a_mp_pend: assert property (@(posedge clk) disable iff (!nrst)
    (st_r == S_DONE && op_r == ncm_pkg::OP_MP_PROG) |=> pend_r)
    else $error("multi program second half not pending"); // [R20]
  a_wait_strobes_high: assert property (@(posedge clk) disable iff (!nrst)
    (st_r == S_WAIT && $past(st_r) == S_WAIT)
    |-> pin_ctl.we_n && pin_ctl.re_n)
    else $error("strobe pulsed while waiting for ready"); // [R3]
  c_read: cover property (@(posedge clk) disable iff (!nrst)
    st_r == S_CMD2 && op_r == ncm_pkg::OP_READ);
  c_mp_read: cover property (@(posedge clk) disable iff (!nrst)
    st_r == S_ADDR2);
  c_status: cover property (@(posedge clk) disable iff (!nrst)
    st_r == S_DATA && op_r == ncm_pkg::OP_STATUS && stb_done);
endmodule

// *** ncm_dev_model.sv ***
`timescale 1ns/1ps
module ncm_dev_model #(
  parameter int LOAD_CYC = 30,
  parameter int XFER_CYC = 4
) (
  // Clock
  input wire logic clk,
  // Host pins
  input wire ncm_pkg::ncm_ctl_s pin_ctl,
  input wire logic [7:0] io_out,
  // Device pins
  output logic [7:0] io_in,
  output logic busy_indicator_n,
  // Fault injection
  input wire logic fail_inj
);
  logic [7:0] cmd_r = 8'h00;
  logic [7:0] dout_r = 8'h00;
  logic [7:0] bpg_r = 8'h00;
  logic [7:0] cpg_r = 8'h00;
  logic [7:0] ab_r [5];
  logic [12:0] col_r = 13'h0;
  logic we_q = 1'b1;
  logic re_q = 1'b1;
  logic stat_r = 1'b0;
  logic cur_r = 1'b0;
  logic prev_r = 1'b0;
  logic mp_r = 1'b0;
  int na = 0;
  int bsy = 0;
  int pend = 0;
  logic [7:0] st;
  logic wr_edge;

  assign st = {pin_ctl.wp_n, bsy == 0, bsy == 0, 3'h0, prev_r, cur_r};
  assign busy_indicator_n = (bsy == 0);
  // Deselected bus shows inverted data so a stale byte never matches
  assign io_in = pin_ctl.ce_n ? ~dout_r : dout_r;
  assign wr_edge = !we_q && pin_ctl.we_n && !pin_ctl.ce_n;

  always @(posedge clk)
  begin
    we_q <= pin_ctl.we_n;
    re_q <= pin_ctl.re_n;
    if (bsy > 0) bsy <= bsy - 1;
    if (pend > 0) pend <= pend - 1;
    if (wr_edge && pin_ctl.ale && !pin_ctl.cle)
    begin
      if (na < 5) ab_r[na] <= io_out;
      if (na == 0) col_r[7:0] <= io_out;
      if (na == 1) col_r[12:8] <= io_out[4:0];
      if (na == 2) bpg_r <= io_out;
      na <= na + 1;
    end
    if (wr_edge && pin_ctl.cle && !pin_ctl.ale &&
        (bsy == 0 || io_out == 8'h70 || io_out == 8'hff))
    begin
      cmd_r <= io_out;
      na <= 0;
      stat_r <= (io_out == 8'h70);
      case (io_out)
        8'h30:
        begin
          bsy <= LOAD_CYC;
          cpg_r <= bpg_r;
        end
        8'h31:
        begin
          bsy <= pend + XFER_CYC;
          pend <= pend + XFER_CYC + LOAD_CYC;
          cpg_r <= bpg_r;
          bpg_r <= bpg_r + 8'h1;
          col_r <= 13'h0;
        end
        8'h3f:
        begin
          bsy <= pend + XFER_CYC;
          cpg_r <= bpg_r;
          col_r <= 13'h0;
        end
        8'h15:
        begin
          bsy <= pend + XFER_CYC;
          pend <= pend + XFER_CYC + LOAD_CYC;
          prev_r <= cur_r;
          cur_r <= fail_inj;
        end
        8'h11:
        begin
          bsy <= XFER_CYC;
          cur_r <= fail_inj;
          mp_r <= 1'b1;
        end
        8'h10:
        begin
          bsy <= pend + LOAD_CYC;
          prev_r <= cur_r;
          cur_r <= fail_inj | (mp_r & cur_r);
          mp_r <= 1'b0;
        end
        8'hff: bsy <= XFER_CYC;
        default: ;
      endcase
    end
    if (re_q && !pin_ctl.re_n && !pin_ctl.ce_n)
    begin
      dout_r <= stat_r ? st : (col_r[7:0] ^ cpg_r);
      col_r <= col_r + 13'h1;
    end
  end
endmodule

// *** tb_ncm_host.sv ***
`timescale 1ns/1ps
module tb_ncm_host;
  logic clk, nrst, psel, penable, pwrite, pready, pslverr, io_oe, e;
  logic busy_indicator_n, fail_inj;
  logic [7:0] paddr, io_out, io_in;
  logic [31:0] pwdata, prdata, q;
  ncm_pkg::ncm_ctl_s pin_ctl;
  int fails, total_checks;

  ncm_host dut_u (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_ctl(pin_ctl),
    .io_out(io_out), .io_oe(io_oe), .io_in(io_in),
    .busy_indicator_n(busy_indicator_n));
  ncm_dev_model dev_u (.clk(clk), .pin_ctl(pin_ctl), .io_out(io_out),
    .io_in(io_in), .busy_indicator_n(busy_indicator_n),
    .fail_inj(fail_inj));

  task automatic chk_byte(input string nm, input logic [7:0] ex,
    input logic [7:0] got);
    total_checks++;
    if (got !== ex)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, ex, got);
    end
  endtask

  task automatic chk_bit(input string nm, input logic ex, input logic got);
    chk_byte(nm, {7'h0, ex}, {7'h0, got});
  endtask

  task automatic apb(input logic wr, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
      fails++;
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic go(input logic [3:0] op, input logic ex_err);
    int n;
    apb(1'b1, ncm_pkg::OFS_CTRL, {27'h0, 1'b1, op});
    n = 0;
    do
    begin
      apb(1'b0, ncm_pkg::OFS_CTRL, 32'h0);
      n++;
    end while (q[4] !== 1'b0 && n < 400);
    if (q[4] !== 1'b0)
      fails++;
    chk_bit("ctrl err", ex_err, q[5]);
  endtask

  task automatic rd_data(input logic [7:0] ex);
    go(4'hc, 1'b0);
    apb(1'b0, ncm_pkg::OFS_RDATA, 32'h0);
    chk_byte("rdata", ex, q[7:0]);
  endtask

  task automatic t_reset();
    chk_byte("pin_ctl", 8'h0f, {2'b0, pin_ctl});
    chk_bit("io_oe", 1'b0, io_oe);
    apb(1'b0, 8'h40, 32'h0);
    chk_bit("pslverr", 1'b1, e);
    $display("t_reset done");
  endtask

  task automatic t_read();
    logic [7:0] ex [5] = '{8'hab, 8'h1f, 8'ha7, 8'hc5, 8'h03};
    apb(1'b1, ncm_pkg::OFS_COL, 32'h0000_ffab);
    // Bits above the row field must not leak onto the fifth cycle
    apb(1'b1, ncm_pkg::OFS_ROW, 32'h0fff_c5a7);
    go(4'h0, 1'b0);
    chk_byte("cmd", 8'h30, dev_u.cmd_r);
    for (int i = 0; i < 5; i++)
      chk_byte("addr", ex[i], dev_u.ab_r[i]);
    rd_data(8'h0c);
    rd_data(8'h0b);
    $display("t_read done");
  endtask

  task automatic t_cache();
    go(4'h1, 1'b0);
    chk_byte("cmd", 8'h31, dev_u.cmd_r);
    rd_data(8'ha7);
    go(4'h2, 1'b0);
    chk_byte("cmd", 8'h3f, dev_u.cmd_r);
    rd_data(8'ha8);
    $display("t_cache done");
  endtask

  task automatic t_multi();
    logic [31:0] r1 [4] = '{32'h105, 32'h1c5, 32'h105, 32'h105};
    logic [31:0] r2 [4] = '{32'h1c5, 32'h105, 32'h1c6, 32'h20045};
    logic ee [4] = '{1'b0, 1'b0, 1'b1, 1'b1};
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, ncm_pkg::OFS_ROW, r1[i]);
      apb(1'b1, ncm_pkg::OFS_ROW2, r2[i]);
      go(4'h3, ee[i]);
      if (!ee[i])
        chk_byte("cmd", 8'h30, dev_u.cmd_r);
    end
    chk_bit("guard", 1'b1, pin_ctl.wp_n);
    $display("t_multi done");
  endtask

  task automatic t_prog();
    apb(1'b1, ncm_pkg::OFS_COL, 32'h0);
    apb(1'b1, ncm_pkg::OFS_ROW, 32'h40);
    go(4'h4, 1'b0);
    chk_byte("cmd", 8'h10, dev_u.cmd_r);
    apb(1'b1, ncm_pkg::OFS_WDATA, 32'h5a);
    go(4'hb, 1'b0);
    apb(1'b1, ncm_pkg::OFS_COL, 32'h10);
    go(4'h8, 1'b0);
    chk_byte("cmd", 8'h85, dev_u.cmd_r);
    chk_byte("col", 8'h10, dev_u.col_r[7:0]);
    go(4'h6, 1'b0);
    chk_byte("cmd", 8'h15, dev_u.cmd_r);
    go(4'h7, 1'b0);
    chk_byte("cmd", 8'h10, dev_u.cmd_r);
    chk_bit("ready", 1'b1, busy_indicator_n);
    go(4'h9, 1'b0);
    apb(1'b0, ncm_pkg::OFS_STAT, 32'h0);
    chk_byte("status", 8'he0, q[7:0]);
    chk_bit("stat ready", 1'b1, q[8]);
    $display("t_prog done");
  endtask

  task automatic t_fail();
    fail_inj <= 1'b1;
    go(4'h5, 1'b0);
    go(4'h4, 1'b0);
    go(4'h7, 1'b0);
    go(4'h9, 1'b0);
    apb(1'b0, ncm_pkg::OFS_STAT, 32'h0);
    chk_bit("fail bit", 1'b1, q[ncm_pkg::ST_FAIL_CUR]);
    $display("t_fail done");
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Whole run needs about a thousand cycles
  initial
  begin
    #(100 * 30000);
    fails++;
    print_verdict();
  end

  initial
  begin
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    fail_inj = 1'b0;
    fails = 0;
    total_checks = 0;
    repeat (8) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_read();
    t_cache();
    t_multi();
    t_prog();
    t_fail();
    print_verdict();
  end
endmodule
